//--- rtl/serial_status.sv
// Contract
// - Noise flag rises with receive full.
// - Noise cleared by status then low read.
// - Framing flag when stop bit is zero.
// - No reception while framing flag set.
// - Framing cleared by status then low read.
// - Parity flag on mismatch when enabled.
// - Parity cleared by status then low read.
// - Status two writes change bits 1,2.
// - Break length 10/11 or 13/14 bits.
// - Break length ignored by receive framing.
// - Direction bit drives pin in single-wire.
// - Active flag on start, cleared on idle.
// - Ninth bits at high bits 7, 6.
// - Transmit ninth bit held across frames.
// - Reads receive buffer, writes transmit buffer.
// - Low register holds eight low bits.
// - Receive full on frame transfer.
// - Overrun keeps buffer, drops new frame.
// - Frame length selects 8 or 9 bits.
`timescale 1ns/10ps
`default_nettype none
module serial_status
	import serial_status_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_stb,
	input  wire logic       rd_stb,
	output logic      [7:0] rdata,
	input  wire rx_frame_s  rx_frame,
	input  wire logic       start_slot_low,
	input  wire logic       idle_detected,
	input  wire logic       parity_enable,
	input  wire logic       parity_odd_select,
	input  wire logic       nine_bit_mode,
	input  wire logic       single_wire_mode,
	input  wire logic       tx_taken,
	output logic      [8:0] tx_word,
	output logic            tx_word_load,
	output logic            txd_oe,
	output logic      [3:0] break_len,
	output logic            rx_accept
);

	state_s s_r;
	state_s s_nxt;

	logic rd_st1;
	logic rd_low;
	logic new_frame;
	logic par_bad;

	function automatic logic parity_of(input logic [8:0] d, input logic nine, input logic odd);
		logic p;
		p = nine ? ^d[7:0] : ^d[6:0];
		return p ^ odd;
	endfunction : parity_of

	always_comb
	begin
		s_nxt = s_r;
		rd_st1 = rd_stb && addr == OFS_LINE_STATUS_ONE;
		rd_low = rd_stb && addr == OFS_DATA_LOW;
		new_frame = rx_frame.valid && !s_r.framing_error_flag;
		par_bad = parity_of(rx_frame.data, nine_bit_mode, parity_odd_select) != rx_frame.parity_bit;
		if (rd_st1)
		begin
			s_nxt.armed = {s_r.noise_flag, s_r.framing_error_flag, s_r.parity_error_flag};
			s_nxt.clr_full_armed = s_r.receive_data_full;
			s_nxt.clr_ovr_armed = s_r.overrun_flag;
		end
		if (rd_low)
		begin
			if (s_r.armed[2])
				s_nxt.noise_flag = 1'b0;
			if (s_r.armed[1])
				s_nxt.framing_error_flag = 1'b0;
			if (s_r.armed[0])
				s_nxt.parity_error_flag = 1'b0;
			if (s_r.clr_full_armed)
				s_nxt.receive_data_full = 1'b0;
			if (s_r.clr_ovr_armed)
				s_nxt.overrun_flag = 1'b0;
			s_nxt.armed = 3'b000;
			s_nxt.clr_full_armed = 1'b0;
			s_nxt.clr_ovr_armed = 1'b0;
		end
		if (new_frame)
		begin
			if (s_r.receive_data_full && !(rd_low && s_r.clr_full_armed))
				s_nxt.overrun_flag = 1'b1;
			else
			begin
				s_nxt.receive_data_full = 1'b1;
				s_nxt.rx_buf = nine_bit_mode ? rx_frame.data : {1'b0, rx_frame.data[7:0]};
				s_nxt.noise_flag = rx_frame.noise;
				s_nxt.framing_error_flag = rx_frame.framing;
				s_nxt.parity_error_flag = parity_enable && par_bad;
			end
		end
		if (start_slot_low)
			s_nxt.receiver_active_flag = 1'b1;
		else if (idle_detected)
			s_nxt.receiver_active_flag = 1'b0;
		if (tx_taken)
			s_nxt.tx_load = 1'b0;
		if (wr_stb)
		begin
			if (addr == OFS_LINE_STATUS_TWO)
			begin
				s_nxt.single_wire_direction = wdata[BIT_DIRECTION];
				s_nxt.break_length_select = wdata[BIT_BREAK_LONG];
			end
			else if (addr == OFS_DATA_HIGH)
				s_nxt.tx_ninth_bit = wdata[BIT_TX_NINTH];
			else if (addr == OFS_DATA_LOW)
			begin
				s_nxt.tx_low = wdata;
				s_nxt.tx_load = 1'b1;
			end
		end
		s_nxt.rdata = RST_BYTE;
		if (rd_stb)
		begin
			if (addr == OFS_LINE_STATUS_ONE)
			begin
				s_nxt.rdata[BIT_PARITY_ERR] = s_r.parity_error_flag;
				s_nxt.rdata[BIT_FRAMING_ERR] = s_r.framing_error_flag;
				s_nxt.rdata[BIT_NOISE] = s_r.noise_flag;
				s_nxt.rdata[BIT_OVERRUN] = s_r.overrun_flag;
				s_nxt.rdata[BIT_RX_FULL] = s_r.receive_data_full;
			end
			else if (addr == OFS_LINE_STATUS_TWO)
			begin
				s_nxt.rdata[BIT_RX_ACTIVE] = s_r.receiver_active_flag;
				s_nxt.rdata[BIT_DIRECTION] = s_r.single_wire_direction;
				s_nxt.rdata[BIT_BREAK_LONG] = s_r.break_length_select;
			end
			else if (addr == OFS_DATA_HIGH)
			begin
				s_nxt.rdata[BIT_RX_NINTH] = s_r.rx_buf[8];
				s_nxt.rdata[BIT_TX_NINTH] = s_r.tx_ninth_bit;
			end
			else if (addr == OFS_DATA_LOW)
				s_nxt.rdata = s_r.rx_buf[7:0];
		end
		s_nxt.txd_oe = !single_wire_mode || s_nxt.single_wire_direction;
		if (s_nxt.break_length_select)
			s_nxt.break_len = nine_bit_mode ? BREAK_LONG_9 : BREAK_LONG_8;
		else
			s_nxt.break_len = nine_bit_mode ? BREAK_SHORT_9 : BREAK_SHORT_8;
		s_nxt.rx_accept = !s_nxt.framing_error_flag;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			s_r <= '0;
			s_r.txd_oe <= 1'b1;
			s_r.break_len <= BREAK_SHORT_8;
			s_r.rx_accept <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	assign rdata = s_r.rdata;
	assign tx_word = {s_r.tx_ninth_bit, s_r.tx_low};
	assign tx_word_load = s_r.tx_load;
	assign txd_oe = s_r.txd_oe;
	assign break_len = s_r.break_len;
	assign rx_accept = s_r.rx_accept;

	property p_noise_set;
		@(posedge mclk) disable iff (sys_rst)
		rx_frame.valid && !s_r.framing_error_flag && !s_r.receive_data_full && rx_frame.noise
		|=> s_r.noise_flag && s_r.receive_data_full;
	endproperty
	a_noise_set: assert property (p_noise_set) else $error("noise not set");

	property p_overrun_keep;
		@(posedge mclk) disable iff (sys_rst)
		rx_frame.valid && !s_r.framing_error_flag && s_r.receive_data_full && !rd_stb
		|=> s_r.overrun_flag && $stable(s_r.rx_buf) && $stable(s_r.noise_flag);
	endproperty
	a_overrun_keep: assert property (p_overrun_keep) else $error("overrun lost data");

	property p_clear_seq;
		@(posedge mclk) disable iff (sys_rst)
		rd_st1 && s_r.noise_flag ##1 !rd_stb && !rx_frame.valid
		##1 rd_low && !rx_frame.valid
		|=> !s_r.noise_flag;
	endproperty
	a_clear_seq: assert property (p_clear_seq) else $error("noise not cleared");

	property p_no_arm_no_clear;
		@(posedge mclk) disable iff (sys_rst)
		rd_stb && addr == OFS_DATA_LOW && s_r.armed == 3'b000 && s_r.parity_error_flag
		|=> s_r.parity_error_flag;
	endproperty
	a_no_arm_no_clear: assert property (p_no_arm_no_clear) else $error("early clear");

	property p_fe_blocks;
		@(posedge mclk) disable iff (sys_rst)
		s_r.framing_error_flag && !rd_stb |=> $stable(s_r.rx_buf);
	endproperty
	a_fe_blocks: assert property (p_fe_blocks) else $error("data taken during framing");

	property p_sr2_write;
		@(posedge mclk) disable iff (sys_rst)
		wr_stb && addr == OFS_LINE_STATUS_TWO
		|=> s_r.single_wire_direction == $past(wdata[BIT_DIRECTION])
		&& s_r.break_length_select == $past(wdata[BIT_BREAK_LONG])
		&& $stable(s_r.receiver_active_flag);
	endproperty
	a_sr2_write: assert property (p_sr2_write) else $error("status two write");

	property p_break;
		@(posedge mclk) disable iff (sys_rst)
		##1 break_len == (s_r.break_length_select ? (nine_bit_mode ? BREAK_LONG_9 : BREAK_LONG_8)
		: (nine_bit_mode ? BREAK_SHORT_9 : BREAK_SHORT_8)) || $changed(nine_bit_mode);
	endproperty
	a_break: assert property (p_break) else $error("break length");

	property p_active;
		@(posedge mclk) disable iff (sys_rst)
		start_slot_low |=> s_r.receiver_active_flag;
	endproperty
	a_active: assert property (p_active) else $error("active flag");

	property p_ninth_hold;
		@(posedge mclk) disable iff (sys_rst)
		!(wr_stb && addr == OFS_DATA_HIGH) |=> $stable(s_r.tx_ninth_bit);
	endproperty
	a_ninth_hold: assert property (p_ninth_hold) else $error("ninth bit changed");

	property p_low_read;
		@(posedge mclk) disable iff (sys_rst)
		rd_stb && addr == OFS_DATA_LOW |=> rdata == $past(s_r.rx_buf[7:0]);
	endproperty
	a_low_read: assert property (p_low_read) else $error("low read");

	property p_noise_arm;
		@(posedge mclk) disable iff (sys_rst)
		rd_st1 && s_r.noise_flag |=> s_r.armed[2];
	endproperty
	a_noise_arm: assert property (p_noise_arm) else $error("noise not armed");

	property p_noise_clear;
		@(posedge mclk) disable iff (sys_rst)
		rd_low && s_r.armed[2] && !rx_frame.valid |=> !s_r.noise_flag;
	endproperty
	a_noise_clear: assert property (p_noise_clear) else $error("armed noise kept");

	property p_framing_set;
		@(posedge mclk) disable iff (sys_rst)
		rx_frame.valid && !s_r.framing_error_flag && !s_r.receive_data_full && rx_frame.framing
		|=> s_r.framing_error_flag && s_r.receive_data_full;
	endproperty
	a_framing_set: assert property (p_framing_set) else $error("framing not set");

	property p_framing_clear;
		@(posedge mclk) disable iff (sys_rst)
		rd_low && s_r.armed[1] && !rx_frame.valid |=> !s_r.framing_error_flag;
	endproperty
	a_framing_clear: assert property (p_framing_clear) else $error("framing not cleared");

	property p_parity_set;
		@(posedge mclk) disable iff (sys_rst)
		rx_frame.valid && !s_r.framing_error_flag && !s_r.receive_data_full && parity_enable
		&& ((nine_bit_mode ? ^rx_frame.data[7:0] : ^rx_frame.data[6:0]) ^ parity_odd_select
		^ rx_frame.parity_bit) |=> s_r.parity_error_flag;
	endproperty
	a_parity_set: assert property (p_parity_set) else $error("parity not set");

	property p_parity_off;
		@(posedge mclk) disable iff (sys_rst)
		rx_frame.valid && !s_r.framing_error_flag && !s_r.receive_data_full && !parity_enable
		|=> !s_r.parity_error_flag;
	endproperty
	a_parity_off: assert property (p_parity_off) else $error("parity set while off");

	property p_parity_clear;
		@(posedge mclk) disable iff (sys_rst)
		rd_low && s_r.armed[0] && !rx_frame.valid |=> !s_r.parity_error_flag;
	endproperty
	a_parity_clear: assert property (p_parity_clear) else $error("parity not cleared");

	property p_overrun_flags;
		@(posedge mclk) disable iff (sys_rst)
		rx_frame.valid && !s_r.framing_error_flag && s_r.receive_data_full && !rd_stb
		|=> $stable(s_r.framing_error_flag) && $stable(s_r.parity_error_flag);
	endproperty
	a_overrun_flags: assert property (p_overrun_flags) else $error("flag set on overrun");

	property p_full_set;
		@(posedge mclk) disable iff (sys_rst)
		rx_frame.valid && !s_r.framing_error_flag |=> s_r.receive_data_full;
	endproperty
	a_full_set: assert property (p_full_set) else $error("receive full missing");

	property p_eight_bit;
		@(posedge mclk) disable iff (sys_rst)
		rx_frame.valid && !s_r.framing_error_flag && !s_r.receive_data_full && !nine_bit_mode
		|=> !s_r.rx_buf[8];
	endproperty
	a_eight_bit: assert property (p_eight_bit) else $error("ninth bit in short frame");

	property p_txd_in;
		@(posedge mclk) disable iff (sys_rst)
		single_wire_mode && !s_r.single_wire_direction && !wr_stb |=> !txd_oe;
	endproperty
	a_txd_in: assert property (p_txd_in) else $error("pin driven as input");

	property p_txd_out;
		@(posedge mclk) disable iff (sys_rst)
		!single_wire_mode |=> txd_oe;
	endproperty
	a_txd_out: assert property (p_txd_out) else $error("pin not driven");

	property p_active_clear;
		@(posedge mclk) disable iff (sys_rst)
		idle_detected && !start_slot_low |=> !s_r.receiver_active_flag;
	endproperty
	a_active_clear: assert property (p_active_clear) else $error("active not cleared");

	property p_high_read;
		@(posedge mclk) disable iff (sys_rst)
		rd_stb && addr == OFS_DATA_HIGH |=> rdata[BIT_RX_NINTH] == $past(s_r.rx_buf[8])
		&& rdata[BIT_TX_NINTH] == $past(s_r.tx_ninth_bit) && rdata[5:0] == 6'h00;
	endproperty
	a_high_read: assert property (p_high_read) else $error("high read");

	property p_tx_load;
		@(posedge mclk) disable iff (sys_rst)
		wr_stb && addr == OFS_DATA_LOW |=> tx_word_load && tx_word[7:0] == $past(wdata);
	endproperty
	a_tx_load: assert property (p_tx_load) else $error("transmit load");

	property p_rx_ninth_fixed;
		@(posedge mclk) disable iff (sys_rst)
		wr_stb && addr == OFS_DATA_HIGH && !rx_frame.valid |=> $stable(s_r.rx_buf);
	endproperty
	a_rx_ninth_fixed: assert property (p_rx_ninth_fixed) else $error("receive bit written");

	property p_status_two_read;
		@(posedge mclk) disable iff (sys_rst)
		rd_stb && addr == OFS_LINE_STATUS_TWO |=> rdata[7:3] == 5'h00;
	endproperty
	a_status_two_read: assert property (p_status_two_read) else $error("status two read");

	property p_rdata_idle;
		@(posedge mclk) disable iff (sys_rst)
		!rd_stb |=> rdata == RST_BYTE;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

	c_frame: cover property (@(posedge mclk) new_frame && !s_r.receive_data_full);
	c_overrun: cover property (@(posedge mclk) new_frame && s_r.receive_data_full);
	c_clear: cover property (@(posedge mclk) rd_low && s_r.armed != 3'b000);
	c_tx: cover property (@(posedge mclk) tx_word_load && tx_taken);
	c_break: cover property (@(posedge mclk) s_r.break_length_select && nine_bit_mode);

endmodule : serial_status
`default_nettype wire

//--- rtl/serial_status_pkg.sv
package serial_status_pkg;

	localparam logic [3:0] OFS_LINE_STATUS_ONE = 4'h4;
	localparam logic [3:0] OFS_LINE_STATUS_TWO = 4'h5;
	localparam logic [3:0] OFS_DATA_HIGH       = 4'h6;
	localparam logic [3:0] OFS_DATA_LOW        = 4'h7;

	localparam int BIT_PARITY_ERR  = 0;
	localparam int BIT_FRAMING_ERR = 1;
	localparam int BIT_NOISE       = 2;
	localparam int BIT_OVERRUN     = 3;
	localparam int BIT_RX_FULL     = 5;

	localparam int BIT_RX_ACTIVE   = 0;
	localparam int BIT_DIRECTION   = 1;
	localparam int BIT_BREAK_LONG  = 2;

	localparam int BIT_RX_NINTH    = 7;
	localparam int BIT_TX_NINTH    = 6;

	localparam logic [7:0] RST_BYTE = 8'h00;

	localparam logic [3:0] BREAK_SHORT_8 = 4'ha;
	localparam logic [3:0] BREAK_SHORT_9 = 4'hb;
	localparam logic [3:0] BREAK_LONG_8  = 4'hd;
	localparam logic [3:0] BREAK_LONG_9  = 4'he;

	typedef struct packed {
		logic       valid;
		logic [8:0] data;
		logic       noise;
		logic       framing;
		logic       parity_bit;
	} rx_frame_s;

	typedef struct packed {
		logic       noise_flag;
		logic       framing_error_flag;
		logic       parity_error_flag;
		logic       receive_data_full;
		logic       overrun_flag;
		logic       receiver_active_flag;
		logic       single_wire_direction;
		logic       break_length_select;
		logic [8:0] rx_buf;
		logic [7:0] tx_low;
		logic       tx_ninth_bit;
		logic       tx_load;
		logic [2:0] armed;
		logic       clr_full_armed;
		logic       clr_ovr_armed;
		logic [7:0] rdata;
		logic       txd_oe;
		logic [3:0] break_len;
		logic       rx_accept;
	} state_s;

endpackage : serial_status_pkg

//--- bench/serial_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module serial_far_model
	import serial_status_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic       go,
	input  wire logic [8:0] d,
	input  wire logic [2:0] err,
	output rx_frame_s       rx_frame,
	input  wire logic       tx_word_load,
	output logic            tx_taken
);
	logic [8:0] last_r;
	logic [2:0] cnt_r;
	// Outside a frame the data lines show the inverted last word, so no stale value can pass.
	assign rx_frame = '{valid: go, data: go ? d : ~last_r, noise: err[2],
		framing: err[1], parity_bit: err[0]};
	always_ff @(posedge mclk)
	begin
		if (go)
			last_r <= d;
		tx_taken <= !sys_rst && tx_word_load && cnt_r == 3'h5;
		cnt_r <= (tx_word_load && !tx_taken) ? cnt_r + 3'h1 : 3'h0;
	end
endmodule : serial_far_model
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
	import serial_status_pkg::*;
;
	logic mclk = 0, sys_rst = 1, wr_stb = 0, rd_stb = 0, go = 0;
	logic pe = 0, odd = 0, nine = 0, sw = 0, ssl = 0, idl = 0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic [8:0] d = 9'h000;
	logic [2:0] err = 3'h0;
	logic [7:0] rdata;
	logic [8:0] tx_word;
	logic [3:0] break_len;
	logic tx_word_load, txd_oe, rx_accept, tx_taken;
	rx_frame_s rx_frame;
	int bad_count = 0, checks = 0;
	always #10 mclk = ~mclk;
	serial_status uut (.mclk(mclk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .rx_frame(rx_frame),
		.start_slot_low(ssl), .idle_detected(idl), .parity_enable(pe),
		.parity_odd_select(odd), .nine_bit_mode(nine), .single_wire_mode(sw),
		.tx_taken(tx_taken), .tx_word(tx_word), .tx_word_load(tx_word_load),
		.txd_oe(txd_oe), .break_len(break_len), .rx_accept(rx_accept));
	serial_far_model far (.mclk(mclk), .sys_rst(sys_rst), .go(go), .d(d), .err(err),
		.rx_frame(rx_frame), .tx_word_load(tx_word_load), .tx_taken(tx_taken));
	task chk(input logic [8:0] s, input logic [8:0] e);
		checks++;
		if (s !== e)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge mclk);
		wr_stb <= 1;
		addr <= a;
		wdata <= v;
		@(posedge mclk);
		wr_stb <= 0;
	endtask : wr
	task rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge mclk);
		rd_stb <= 1;
		addr <= a;
		@(posedge mclk);
		rd_stb <= 0;
		#1;
		chk({1'b0, rdata & m}, {1'b0, e});
	endtask : rdc
	task frame(input logic [8:0] v, input logic [2:0] e);
		@(posedge mclk);
		go <= 1;
		d <= v;
		err <= e;
		@(posedge mclk);
		go <= 0;
	endtask : frame
	task settle;
		repeat (2) @(posedge mclk);
		#1;
	endtask : settle
	task finish_test;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	initial
	begin
		#500000;
		bad_count++;
		finish_test;
	end
	initial
	begin
		repeat (5) @(posedge mclk);
		sys_rst <= 0;
		settle;
		chk(break_len, BREAK_SHORT_8);
		chk(txd_oe, 1);
		rdc(OFS_LINE_STATUS_TWO, 8'hff, 8'h00);
		wr(4'h0, 8'hff);
		rdc(4'h0, 8'hff, 8'h00);
		nine <= 1;
		frame(9'h1a5, 3'h4);
		rdc(OFS_LINE_STATUS_ONE, 8'hff, 8'h24);
		rdc(OFS_DATA_HIGH, 8'hbf, 8'h80);
		rdc(OFS_DATA_LOW, 8'hff, 8'ha5);
		rdc(OFS_LINE_STATUS_ONE, 8'hff, 8'h00);
		// A flag raised between the two reads survives the sequence.
		rdc(OFS_LINE_STATUS_ONE, 8'hff, 8'h00);
		frame(9'h011, 3'h4);
		rdc(OFS_DATA_LOW, 8'hff, 8'h11);
		rdc(OFS_LINE_STATUS_ONE, 8'hff, 8'h24);
		rdc(OFS_DATA_LOW, 8'hff, 8'h11);
		frame(9'h0c3, 3'h0);
		frame(9'h03c, 3'h4);
		rdc(OFS_LINE_STATUS_ONE, 8'hff, 8'h28);
		rdc(OFS_DATA_LOW, 8'hff, 8'hc3);
		rdc(OFS_LINE_STATUS_ONE, 8'hff, 8'h00);
		wr(OFS_LINE_STATUS_TWO, 8'hff);
		rdc(OFS_LINE_STATUS_TWO, 8'hff, 8'h06);
		frame(9'h055, 3'h2);
		rdc(OFS_LINE_STATUS_ONE, 8'hff, 8'h22);
		chk(rx_accept, 0);
		frame(9'h0aa, 3'h0);
		rdc(OFS_LINE_STATUS_ONE, 8'hff, 8'h22);
		rdc(OFS_DATA_LOW, 8'hff, 8'h55);
		rdc(OFS_LINE_STATUS_ONE, 8'hff, 8'h00);
		chk(rx_accept, 1);
		pe <= 1;
		for (int i = 0; i < 4; i++)
		begin
			nine <= i[1];
			odd <= i[0];
			frame(9'h183, 3'h1);
			rdc(OFS_LINE_STATUS_ONE, 8'hff, (i[0] ^ i[1]) ? 8'h20 : 8'h21);
			rdc(OFS_DATA_HIGH, 8'h80, i[1] ? 8'h80 : 8'h00);
			rdc(OFS_DATA_LOW, 8'hff, 8'h83);
			rdc(OFS_LINE_STATUS_ONE, 8'hff, 8'h00);
		end
		for (int i = 0; i < 4; i++)
		begin
			nine <= i[0];
			wr(OFS_LINE_STATUS_TWO, {5'h00, i[1], 2'h0});
			settle;
			chk(break_len, i[1] ? (i[0] ? BREAK_LONG_9 : BREAK_LONG_8)
				: (i[0] ? BREAK_SHORT_9 : BREAK_SHORT_8));
		end
		sw <= 1;
		wr(OFS_LINE_STATUS_TWO, 8'h00);
		settle;
		chk(txd_oe, 0);
		wr(OFS_LINE_STATUS_TWO, 8'h02);
		settle;
		chk(txd_oe, 1);
		sw <= 0;
		wr(OFS_LINE_STATUS_TWO, 8'h00);
		settle;
		chk(txd_oe, 1);
		@(posedge mclk) ssl <= 1;
		@(posedge mclk) ssl <= 0;
		rdc(OFS_LINE_STATUS_TWO, 8'h01, 8'h01);
		@(posedge mclk) idl <= 1;
		@(posedge mclk) idl <= 0;
		rdc(OFS_LINE_STATUS_TWO, 8'h01, 8'h00);
		// High byte first so the low write launches a complete word.
		wr(OFS_DATA_HIGH, 8'h40);
		wr(OFS_DATA_LOW, 8'h5a);
		settle;
		chk(tx_word, 9'h15a);
		chk(tx_word_load, 1);
		repeat (10) @(posedge mclk);
		#1;
		chk(tx_word_load, 0);
		wr(OFS_DATA_LOW, 8'h33);
		settle;
		chk(tx_word, 9'h133);
		wr(OFS_DATA_HIGH, 8'h00);
		rdc(OFS_DATA_HIGH, 8'h80, 8'h80);
		finish_test;
	end
endmodule : tb
`default_nettype wire
